// File: design/cmad_consts.svh
`ifndef CMAD_CONSTS_SVH
`define CMAD_CONSTS_SVH

// data space layout
`define CMAD_DATA_AW        8
`define CMAD_UPPER_BIT      7
`define CMAD_BANK_BASE      8'h00
`define CMAD_BIT_AREA_BASE  8'h20
`define CMAD_BIT_SFR_BIT    7

// stack pointer value after reset
`define CMAD_SP_RESET       8'h07

// program store
`define CMAD_CODE_AW        13
`define CMAD_CODE_SIZE      17'h02000
`define CMAD_RESET_VECTOR   16'h0000
`define CMAD_VEC_BASE       16'h0003
`define CMAD_VEC_SHIFT      3

// instruction length in clock cycles
`define CMAD_CYC_MIN        3'h1
`define CMAD_CYC_MAX        3'h6

`endif

// File: design/cmad_pkg.sv
package cmad_pkg;

  typedef enum logic [3:0] {
    CMAD_M_NONE = 4'h0,
    CMAD_M_DIR  = 4'h1,
    CMAD_M_IND  = 4'h2,
    CMAD_M_REG  = 4'h3,
    CMAD_M_IMM  = 4'h4,
    CMAD_M_BIT  = 4'h5,
    CMAD_M_PUSH = 4'h6,
    CMAD_M_POP  = 4'h7,
    CMAD_M_IXDP = 4'h8,
    CMAD_M_IXPC = 4'h9,
    CMAD_M_JMPX = 4'hA,
    CMAD_M_XMOV = 4'hB
  } cmad_mode_t;

  typedef enum logic [2:0] {
    CMAD_T_NONE  = 3'h0,
    CMAD_T_LOW   = 3'h1,
    CMAD_T_UPPER = 3'h2,
    CMAD_T_SFR   = 3'h3,
    CMAD_T_CODE  = 3'h4
  } cmad_tgt_t;

  typedef struct packed {
    logic       valid;
    cmad_mode_t mode;
    logic       write;
    logic [7:0] operand;
    logic [2:0] reg_sel;
    logic [7:0] wdata;
    logic       bit_val;
  } cmad_req_t;

  typedef struct packed {
    logic       valid;
    cmad_tgt_t  target;
    logic [7:0] addr;
    logic [7:0] rdata;
    logic [2:0] bit_pos;
    logic       fault;
  } cmad_rsp_t;

  typedef struct packed {
    logic        bank_load;
    logic [1:0]  bank;
    logic        sp_load;
    logic [7:0]  sp;
    logic        dp_load;
    logic [15:0] dp;
  } cmad_ctl_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic        bit_en;
    logic [2:0]  bit_pos;
    logic        bit_val;
  } cmad_sfr_t;

endpackage

// File: design/cmad_bit_decode.sv
`timescale 1ns/1ps
`include "cmad_consts.svh"

// splits a bit address into byte address and bit position
module cmad_bit_decode
  import cmad_pkg::*;
(
  input  wire logic [7:0] bit_addr,
  output logic      [7:0] byte_addr,
  output logic      [2:0] bit_pos,
  output logic            is_sfr
);

  // low half lands in the 16-byte area, high half on sfrs ending in 0H or 8H
  wire logic [7:0] ram_byte;
  wire logic [7:0] sfr_byte;

  assign is_sfr    = bit_addr[`CMAD_BIT_SFR_BIT];
  assign ram_byte  = `CMAD_BIT_AREA_BASE + {4'h0, bit_addr[6:3]};
  assign sfr_byte  = {bit_addr[7:3], 3'h0};
  assign byte_addr = is_sfr ? sfr_byte : ram_byte;
  assign bit_pos   = bit_addr[2:0];

endmodule

// File: design/cmad_top.sv
`timescale 1ns/1ps
`include "cmad_consts.svh"

// How it works
// - instructions take one to six clock cycles
// - direct mode uses instruction address byte
// - 8-bit indirect via work regs or stack
// - 3-bit opcode field picks bank register
// - indexed reads program store, base plus accumulator
// - indexed jump target is base plus accumulator
// - program store read-only, eight kilobytes, on-chip
// - program counter starts at zero after reset
// - interrupt vectors fixed, eight bytes apart
// - high half selects sfr or upper ram
// - direct high goes sfr, indirect high ram
// - upper 128 bytes reached only indirectly
// - lowest 32 bytes are four register banks
// - sixteen bytes above banks are bit-addressable
// - sfrs direct only; 0H/8H ones bit-addressable
// - no external data memory target exists
// - two status bits choose the active bank
// - stack pointer pre-increments, resets to 07H
module cmad_top
  import cmad_pkg::*;
#(
  parameter int DATA_DEPTH = 256
)
(
  input  wire logic                     sys_clk,
  input  wire logic                     rst_b,
  input  wire cmad_req_t                req,
  input  wire cmad_ctl_t                ctl,
  input  wire logic [7:0]               acc,
  input  wire logic                     fetch_step,
  input  wire logic [2:0]               fetch_len,
  input  wire logic                     irq_take,
  input  wire logic [1:0]               irq_src,
  input  wire logic                     instr_start,
  input  wire logic [2:0]               instr_cycles,
  output cmad_rsp_t                     rsp,
  output cmad_sfr_t                     sfr,
  output logic                          code_rd,
  output logic [`CMAD_CODE_AW-1:0]      code_addr,
  output logic [`CMAD_CODE_AW-1:0]      fetch_addr,
  output logic                          code_fault,
  output logic [1:0]                    bank_sel,
  output logic [7:0]                    stack_pointer,
  output logic [15:0]                   data_pointer,
  output logic                          instr_busy,
  output logic                          instr_last
);

  // register number plus bank base gives the data byte
  function automatic logic [7:0] reg_byte(input logic [1:0] bank, input logic [2:0] idx);
    reg_byte = `CMAD_BANK_BASE + {3'h0, bank, idx};
  endfunction

  // true when a byte sits in the upper half of the data space
  function automatic logic is_high(input logic [7:0] a);
    is_high = a[`CMAD_UPPER_BIT];
  endfunction

  // reset release through two flops
  logic rst_s1_q;
  logic rst_s2_q;
  wire  logic rst_n_int;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n_int = rst_s2_q;

  // internal scratch-pad; upper and lower halves share one array
  logic [7:0] ram [DATA_DEPTH];

  logic [1:0]  bank_q;
  logic [1:0]  bank_d;
  logic [7:0]  sp_q;
  logic [7:0]  sp_d;
  logic [15:0] dp_q;
  logic [15:0] dp_d;
  logic [15:0] pc_q;
  logic [15:0] pc_d;
  logic [2:0]  cyc_q;
  logic [2:0]  cyc_d;
  cmad_rsp_t   rsp_q;
  cmad_rsp_t   rsp_d;
  cmad_sfr_t   sfr_q;
  cmad_sfr_t   sfr_d;
  logic        code_rd_q;
  logic [`CMAD_CODE_AW-1:0] code_addr_q;
  logic        code_fault_q;

  // request mode decode
  wire logic req_on;
  wire logic m_dir;
  wire logic m_ind;
  wire logic m_reg;
  wire logic m_imm;
  wire logic m_bit;
  wire logic m_push;
  wire logic m_pop;
  wire logic m_ixdp;
  wire logic m_ixpc;
  wire logic m_jmpx;
  wire logic m_xmov;

  assign req_on = req.valid;
  assign m_dir  = req_on && (req.mode == CMAD_M_DIR);
  assign m_ind  = req_on && (req.mode == CMAD_M_IND);
  assign m_reg  = req_on && (req.mode == CMAD_M_REG);
  assign m_imm  = req_on && (req.mode == CMAD_M_IMM);
  assign m_bit  = req_on && (req.mode == CMAD_M_BIT);
  assign m_push = req_on && (req.mode == CMAD_M_PUSH);
  assign m_pop  = req_on && (req.mode == CMAD_M_POP);
  assign m_ixdp = req_on && (req.mode == CMAD_M_IXDP);
  assign m_ixpc = req_on && (req.mode == CMAD_M_IXPC);
  assign m_jmpx = req_on && (req.mode == CMAD_M_JMPX);
  assign m_xmov = req_on && (req.mode == CMAD_M_XMOV);

  // register-form and pointer addresses in the active bank
  wire logic [7:0] reg_addr;
  wire logic [7:0] ptr_loc;
  wire logic [7:0] ptr_val;

  assign reg_addr = reg_byte(bank_q, req.reg_sel);
  assign ptr_loc  = reg_byte(bank_q, {2'h0, req.reg_sel[0]});
  assign ptr_val  = ram[ptr_loc];

  // direct byte address, high half steers to sfr space
  wire logic dir_sfr;
  assign dir_sfr = is_high(req.operand);

  // stack walks the whole array as indirect space
  wire logic [7:0] sp_inc;
  wire logic [7:0] sp_dec;
  assign sp_inc = sp_q + 8'h01;
  assign sp_dec = sp_q - 8'h01;

  // bit address split
  wire logic [7:0] bit_byte;
  wire logic [2:0] bit_pos;
  wire logic       bit_sfr;

  cmad_bit_decode u_bit_decode
  (
    .bit_addr  (req.operand),
    .byte_addr (bit_byte),
    .bit_pos   (bit_pos),
    .is_sfr    (bit_sfr)
  );

  // indexed sums; 17 bits so a table past the store is caught
  wire logic [15:0] ix_base;
  wire logic [16:0] ix_sum;
  wire logic        ix_over;

  assign ix_base = m_ixpc ? pc_q : dp_q;
  assign ix_sum  = {1'b0, ix_base} + {9'h000, acc};
  assign ix_over = (ix_sum >= `CMAD_CODE_SIZE);

  // ram address and write enable per mode
  logic [7:0] ram_a;
  logic       ram_we;
  logic [7:0] ram_wd;
  wire  logic [7:0] ram_rd;
  wire  logic [7:0] bit_mask;

  assign bit_mask = 8'h01 << bit_pos;

  always_comb
  begin
    ram_a  = 8'h00;
    ram_we = 1'b0;
    ram_wd = req.wdata;
    if (m_dir && !dir_sfr)
    begin
      ram_a  = req.operand;
      ram_we = req.write;
    end
    else if (m_ind)
    begin
      ram_a  = ptr_val;
      ram_we = req.write;
    end
    else if (m_reg)
    begin
      ram_a  = reg_addr;
      ram_we = req.write;
    end
    else if (m_bit && !bit_sfr)
    begin
      ram_a  = bit_byte;
      ram_we = req.write;
      ram_wd = req.bit_val ? (ram[bit_byte] | bit_mask) : (ram[bit_byte] & ~bit_mask);
    end
    else if (m_push)
    begin
      ram_a  = sp_inc;
      ram_we = 1'b1;
    end
    else if (m_pop)
    begin
      ram_a  = sp_q;
    end
  end

  assign ram_rd = ram[ram_a];

  // array has no reset; contents are undefined until written
  always_ff @(posedge sys_clk)
  begin
    if (ram_we)
      ram[ram_a] <= ram_wd;
  end

  // response and sfr strobes for the cycle after the request
  always_comb
  begin
    rsp_d         = '0;
    rsp_d.valid   = req_on;
    rsp_d.target  = CMAD_T_NONE;
    sfr_d         = '0;
    sfr_d.addr    = req.operand;
    sfr_d.wdata   = req.wdata;
    sfr_d.bit_pos = bit_pos;
    sfr_d.bit_val = req.bit_val;
    if (m_dir && dir_sfr)
    begin
      rsp_d.target = CMAD_T_SFR;
      rsp_d.addr   = req.operand;
      sfr_d.rd     = !req.write;
      sfr_d.wr     = req.write;
    end
    else if (m_bit && bit_sfr)
    begin
      rsp_d.target  = CMAD_T_SFR;
      rsp_d.addr    = bit_byte;
      rsp_d.bit_pos = bit_pos;
      sfr_d.addr    = bit_byte;
      sfr_d.rd      = !req.write;
      sfr_d.wr      = req.write;
      sfr_d.bit_en  = 1'b1;
    end
    else if (m_dir || m_ind || m_reg || m_bit || m_push || m_pop)
    begin
      rsp_d.target  = is_high(ram_a) ? CMAD_T_UPPER : CMAD_T_LOW;
      rsp_d.addr    = ram_a;
      rsp_d.rdata   = m_bit ? {7'h00, ram_rd[bit_pos]} : ram_rd;
      rsp_d.bit_pos = bit_pos;
    end
    else if (m_imm)
    begin
      rsp_d.rdata = req.operand;
    end
    else if (m_ixdp || m_ixpc || m_jmpx)
    begin
      rsp_d.target = ix_over ? CMAD_T_NONE : CMAD_T_CODE;
      rsp_d.fault  = ix_over || (req.write && !m_jmpx);
    end
    else if (m_xmov || (req_on && req.mode == CMAD_M_NONE))
    begin
      rsp_d.fault = 1'b1;
    end
  end

  // bank, stack and data pointer; software loads win over stack moves
  always_comb
  begin
    bank_d = ctl.bank_load ? ctl.bank : bank_q;
    dp_d   = ctl.dp_load ? ctl.dp : dp_q;
    sp_d   = sp_q;
    if (ctl.sp_load)
      sp_d = ctl.sp;
    else if (m_push)
      sp_d = sp_inc;
    else if (m_pop)
      sp_d = sp_dec;
  end

  // program counter: vector beats indexed jump beats plain stepping
  wire logic [15:0] vec_addr;
  assign vec_addr = `CMAD_VEC_BASE + ({14'h0000, irq_src} << `CMAD_VEC_SHIFT);

  always_comb
  begin
    pc_d = pc_q;
    if (irq_take)
      pc_d = vec_addr;
    else if (m_jmpx && !ix_over)
      pc_d = ix_sum[15:0];
    else if (fetch_step)
      pc_d = pc_q + {13'h0000, fetch_len};
  end

  // cycle count of the running instruction, clamped to one..six
  wire logic [2:0] cyc_len;
  assign cyc_len = (instr_cycles < `CMAD_CYC_MIN) ? `CMAD_CYC_MIN :
                   (instr_cycles > `CMAD_CYC_MAX) ? `CMAD_CYC_MAX : instr_cycles;

  always_comb
  begin
    cyc_d = cyc_q;
    if (instr_start)
      cyc_d = cyc_len - 3'h1;
    else if (cyc_q != 3'h0)
      cyc_d = cyc_q - 3'h1;
  end

  // state registers
  always_ff @(posedge sys_clk or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      bank_q <= 2'h0;
      sp_q   <= `CMAD_SP_RESET;
      dp_q   <= 16'h0000;
      pc_q   <= `CMAD_RESET_VECTOR;
      cyc_q  <= 3'h0;
    end
    else
    begin
      bank_q <= bank_d;
      sp_q   <= sp_d;
      dp_q   <= dp_d;
      pc_q   <= pc_d;
      cyc_q  <= cyc_d;
    end
  end

  // registered answers; code port never writes
  always_ff @(posedge sys_clk or negedge rst_n_int)
  begin
    if (!rst_n_int)
    begin
      rsp_q        <= '0;
      sfr_q        <= '0;
      code_rd_q    <= 1'b0;
      code_addr_q  <= '0;
      code_fault_q <= 1'b0;
    end
    else
    begin
      rsp_q        <= rsp_d;
      sfr_q        <= sfr_d;
      code_rd_q    <= (m_ixdp || m_ixpc) && !req.write && !ix_over;
      code_addr_q  <= ix_sum[`CMAD_CODE_AW-1:0];
      code_fault_q <= (m_ixdp || m_ixpc || m_jmpx) && ix_over;
    end
  end

  assign rsp           = rsp_q;
  assign sfr           = sfr_q;
  assign code_rd       = code_rd_q;
  assign code_addr     = code_addr_q;
  assign code_fault    = code_fault_q;
  assign fetch_addr    = pc_q[`CMAD_CODE_AW-1:0];
  assign bank_sel      = bank_q;
  assign stack_pointer = sp_q;
  assign data_pointer  = dp_q;
  assign instr_busy    = (cyc_q != 3'h0);
  // last cycle of an instruction, combinational for the sequencer
  assign instr_last    = instr_start ? (cyc_len == 3'h1) : (cyc_q == 3'h1);

endmodule

// File: sim/cmad_assertions.sv
`timescale 1ns/1ps
`include "cmad_consts.svh"

// watches addressing outcomes at the top ports
module cmad_chk
  import cmad_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire cmad_req_t   req,
  input wire cmad_ctl_t   ctl,
  input wire logic [7:0]  acc,
  input wire logic        irq_take,
  input wire logic [1:0]  irq_src,
  input wire logic        instr_start,
  input wire logic [2:0]  instr_cycles,
  input wire cmad_rsp_t   rsp,
  input wire cmad_sfr_t   sfr,
  input wire logic        code_rd,
  input wire logic [12:0] code_addr,
  input wire logic [12:0] fetch_addr,
  input wire logic [1:0]  bank_sel,
  input wire logic [7:0]  stack_pointer,
  input wire logic [15:0] data_pointer,
  input wire logic        instr_busy,
  input wire logic        instr_last
);
  // 17 bits so an overflow past the program store stays visible
  wire [16:0] dp_sum = {1'b0, data_pointer} + {9'h000, acc};
  // a write on either indexed form, table read by pc or by data pointer
  wire        ix_wr  = req.valid && req.write && (req.mode == CMAD_M_IXDP || req.mode == CMAD_M_IXPC);

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence s_req(cmad_mode_t m);
    req.valid && req.mode == m;
  endsequence
  // three-cycle instruction: two busy cycles, last flagged in the second
  sequence s_three;
    instr_busy && !instr_last ##1 instr_busy && instr_last ##1 !instr_busy;
  endsequence

  a_dir_high_sfr: assert property (s_req(CMAD_M_DIR) ##0 req.operand[7] |=>
    rsp.target == CMAD_T_SFR && sfr.addr == $past(req.operand)) else $error("direct high missed sfr");
  a_ind_no_sfr: assert property (s_req(CMAD_M_IND) |=>
    rsp.target != CMAD_T_SFR && !sfr.rd && !sfr.wr) else $error("indirect reached sfr");
  a_reg_bank_addr: assert property (s_req(CMAD_M_REG) |=>
    rsp.addr == {3'h0, $past(bank_sel), $past(req.reg_sel)}) else $error("register address wrong");
  a_push_pre_inc: assert property (s_req(CMAD_M_PUSH) ##0 !ctl.sp_load |=>
    stack_pointer == $past(stack_pointer) + 8'h01 && rsp.addr == stack_pointer) else $error("push not pre-inc");
  a_index_read: assert property (s_req(CMAD_M_IXDP) ##0 (!req.write && dp_sum < 17'h02000) |=>
    code_rd && {4'h0, code_addr} == $past(dp_sum)) else $error("indexed read address wrong");
  a_index_no_write: assert property (ix_wr |=>
    rsp.fault && !code_rd) else $error("indexed write accepted");
  a_jump_sum: assert property (s_req(CMAD_M_JMPX) ##0 (!irq_take && dp_sum < 17'h02000) |=>
    {4'h0, fetch_addr} == $past(dp_sum)) else $error("jump target wrong");
  a_vector_fixed: assert property (irq_take |=>
    fetch_addr == 13'h0003 + {8'h00, $past(irq_src), 3'h0}) else $error("vector wrong");
  a_ext_move_fault: assert property (s_req(CMAD_M_XMOV) |=>
    rsp.fault && rsp.target == CMAD_T_NONE && !sfr.wr) else $error("external move not refused");
  a_bank_load: assert property (ctl.bank_load |=>
    bank_sel == $past(ctl.bank)) else $error("bank not loaded");
  a_instr_three: assert property (instr_start && instr_cycles == 3'h3 && !instr_busy |=> s_three)
    else $error("instruction length wrong");
endmodule

bind cmad_top cmad_chk chk_u (.sys_clk(sys_clk), .rst_b(rst_b), .req(req), .ctl(ctl), .acc(acc),
  .irq_take(irq_take), .irq_src(irq_src), .instr_start(instr_start), .instr_cycles(instr_cycles),
  .rsp(rsp), .sfr(sfr), .code_rd(code_rd), .code_addr(code_addr), .fetch_addr(fetch_addr),
  .bank_sel(bank_sel), .stack_pointer(stack_pointer), .data_pointer(data_pointer),
  .instr_busy(instr_busy), .instr_last(instr_last));

// File: sim/tb_top.sv
`timescale 1ns/1ps

module tb_top
  import cmad_pkg::*;
;
  logic        sys_clk, rst_b, fetch_step, irq_take, instr_start, code_rd, code_fault, instr_busy, instr_last;
  logic        crd, cfl;
  logic [2:0]  fetch_len, instr_cycles;
  logic [1:0]  irq_src, bank_sel;
  logic [7:0]  acc, stack_pointer;
  logic [12:0] code_addr, fetch_addr;
  logic [15:0] data_pointer;
  cmad_req_t   req;
  cmad_ctl_t   ctl;
  cmad_rsp_t   rsp, rs;
  cmad_sfr_t   sfr, sf;
  int          fail_count, checks_done;

  cmad_top dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .req(req), .ctl(ctl), .acc(acc), .fetch_step(fetch_step),
    .fetch_len(fetch_len), .irq_take(irq_take), .irq_src(irq_src), .instr_start(instr_start),
    .instr_cycles(instr_cycles), .rsp(rsp), .sfr(sfr), .code_rd(code_rd), .code_addr(code_addr),
    .fetch_addr(fetch_addr), .code_fault(code_fault), .bank_sel(bank_sel), .stack_pointer(stack_pointer),
    .data_pointer(data_pointer), .instr_busy(instr_busy), .instr_last(instr_last));

  // 200 MHz
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one request, answer captured the cycle after it is taken
  task automatic op(input cmad_mode_t m, input logic w, input logic [7:0] opd, input logic [2:0] r,
                    input logic [7:0] wd);
    @(posedge sys_clk);
    req <= '{1'b1, m, w, opd, r, wd, 1'b1};
    @(posedge sys_clk);
    req <= '0;
    #1;
    rs = rsp;
    sf = sfr;
    crd = code_rd;
    cfl = code_fault;
  endtask

  task automatic load(input cmad_ctl_t c, input logic [7:0] a);
    @(posedge sys_clk);
    ctl <= c;
    acc <= a;
    @(posedge sys_clk);
    ctl <= '0;
  endtask

  task automatic t_banks;
    for (int b = 0; b < 4; b++)
    begin
      load('{1'b1, 2'(b), 1'b0, 8'h00, 1'b0, 16'h0000}, 8'h00);
      #1 chk(bank_sel, b);
      op(CMAD_M_REG, 1'b1, 8'h00, 3'h5, 8'(8'hA0 + b));
      chk(rs.addr, 8 * b + 5);
      chk({rs.valid, rs.target}, {1'b1, CMAD_T_LOW});
    end
    // top register of the last bank closes the bank area
    op(CMAD_M_REG, 1'b0, 8'h00, 3'h7, 8'h00);
    chk(rs.addr, 8'h1F);
    // banks must not alias each other
    for (int b = 0; b < 4; b++)
    begin
      op(CMAD_M_DIR, 1'b0, 8'(8 * b + 5), 3'h0, 8'h00);
      chk(rs.rdata, 8'hA0 + b);
      chk(rs.target, CMAD_T_LOW);
    end
    load('{1'b1, 2'h0, 1'b0, 8'h00, 1'b0, 16'h0000}, 8'h00);
  endtask

  task automatic t_high;
    op(CMAD_M_DIR, 1'b1, 8'h90, 3'h0, 8'h11);
    chk(sf.wr, 1'b1);
    chk({sf.rd, sf.addr, sf.wdata}, {1'b0, 8'h90, 8'h11});
    op(CMAD_M_REG, 1'b1, 8'h00, 3'h0, 8'h90);
    op(CMAD_M_IND, 1'b1, 8'h00, 3'h0, 8'h5A);
    chk({rs.target, rs.addr}, {CMAD_T_UPPER, 8'h90});
    chk(sf.wr, 1'b0);
    op(CMAD_M_IND, 1'b0, 8'h00, 3'h0, 8'h00);
    chk(rs.rdata, 8'h5A);
    // the same address taken directly must miss the upper byte
    op(CMAD_M_DIR, 1'b0, 8'h90, 3'h0, 8'h00);
    chk(rs.target, CMAD_T_SFR);
    chk({sf.rd, rs.rdata}, {1'b1, 8'h00});
  endtask

  task automatic t_bits;
    op(CMAD_M_DIR, 1'b1, 8'h21, 3'h0, 8'h00);
    op(CMAD_M_BIT, 1'b1, 8'h0B, 3'h0, 8'h00);
    op(CMAD_M_DIR, 1'b0, 8'h21, 3'h0, 8'h00);
    chk(rs.rdata, 8'h08);
    op(CMAD_M_BIT, 1'b1, 8'h8B, 3'h0, 8'h00);
    chk({sf.bit_en, sf.addr, sf.bit_pos, sf.bit_val, rs.bit_pos}, {1'b1, 8'h88, 3'h3, 1'b1, 3'h3});
  endtask

  task automatic t_stack;
    op(CMAD_M_PUSH, 1'b1, 8'h00, 3'h0, 8'h33);
    chk({stack_pointer, rs.addr}, 16'h0808);
    op(CMAD_M_PUSH, 1'b1, 8'h00, 3'h0, 8'h44);
    op(CMAD_M_POP, 1'b0, 8'h00, 3'h0, 8'h00);
    chk({stack_pointer, rs.rdata}, 16'h0844);
  endtask

  task automatic t_index;
    load('{1'b0, 2'h0, 1'b0, 8'h00, 1'b1, 16'h1000}, 8'h20);
    #1 chk(data_pointer, 16'h1000);
    op(CMAD_M_IXDP, 1'b0, 8'h00, 3'h0, 8'h00);
    chk({crd, code_addr, rs.target}, {1'b1, 13'h1020, CMAD_T_CODE});
    op(CMAD_M_IXDP, 1'b1, 8'h00, 3'h0, 8'h00);
    chk({rs.fault, crd}, 2'b10);
    // sum past the 8K store must not wrap into low code
    load('{1'b0, 2'h0, 1'b0, 8'h00, 1'b1, 16'h1FF0}, 8'h20);
    op(CMAD_M_IXDP, 1'b0, 8'h00, 3'h0, 8'h00);
    chk({cfl, crd}, 2'b10);
    load('{1'b0, 2'h0, 1'b0, 8'h00, 1'b1, 16'h0100}, 8'h05);
    op(CMAD_M_JMPX, 1'b0, 8'h00, 3'h0, 8'h00);
    chk(fetch_addr, 13'h0105);
    op(CMAD_M_IXPC, 1'b0, 8'h00, 3'h0, 8'h00);
    chk(code_addr, 13'h010A);
    op(CMAD_M_XMOV, 1'b1, 8'h05, 3'h5, 8'hFF);
    chk({rs.fault, rs.target}, {1'b1, CMAD_T_NONE});
    op(CMAD_M_NONE, 1'b1, 8'h05, 3'h5, 8'hFF);
    chk({rs.fault, rs.target}, {1'b1, CMAD_T_NONE});
    // refused writes must leave the register byte untouched
    op(CMAD_M_DIR, 1'b0, 8'h05, 3'h0, 8'h00);
    chk(rs.rdata, 8'hA0);
    op(CMAD_M_IMM, 1'b0, 8'h3C, 3'h0, 8'h00);
    chk({rs.valid, rs.target, rs.rdata, rs.fault}, {1'b1, CMAD_T_NONE, 8'h3C, 1'b0});
  endtask

  task automatic t_pc;
    for (int s = 0; s < 4; s++)
    begin
      @(posedge sys_clk);
      irq_take <= 1'b1;
      irq_src <= 2'(s);
      @(posedge sys_clk);
      irq_take <= 1'b0;
      #1 chk(fetch_addr, 3 + 8 * s);
    end
    @(posedge sys_clk);
    fetch_step <= 1'b1;
    fetch_len <= 3'h3;
    @(posedge sys_clk);
    fetch_step <= 1'b0;
    #1 chk(fetch_addr, 13'h001E);
  endtask

  // reset in mid-run brings counter, pointers and answers back to their start
  task automatic t_reset;
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    #1 chk({fetch_addr, instr_busy, rsp.valid}, {13'h0000, 1'b0, 1'b0});
    repeat (3) @(posedge sys_clk);
    #1 chk({stack_pointer, bank_sel, data_pointer}, {8'h07, 2'h0, 16'h0000});
    chk(fetch_addr, 13'h0000);
  endtask

  task automatic t_instr;
    int n;
    @(posedge sys_clk);
    instr_start <= 1'b1;
    instr_cycles <= 3'h3;
    #1 chk(instr_last, 1'b0);
    for (int i = 0; i < 3; i++)
    begin
      @(posedge sys_clk);
      instr_start <= 1'b0;
      #1 chk({instr_busy, instr_last}, (i == 0) ? 2'b10 : (i == 1) ? 2'b11 : 2'b00);
    end
    // zero is clamped to one: last at once, never busy
    @(posedge sys_clk);
    instr_start <= 1'b1;
    instr_cycles <= 3'h0;
    #1 chk(instr_last, 1'b1);
    @(posedge sys_clk);
    instr_start <= 1'b0;
    #1 chk({instr_busy, instr_last}, 2'b00);
    // seven is clamped to six: five busy cycles follow the start
    n = 0;
    @(posedge sys_clk);
    instr_start <= 1'b1;
    instr_cycles <= 3'h7;
    for (int i = 0; i < 7; i++)
    begin
      @(posedge sys_clk);
      instr_start <= 1'b0;
      #1 n += int'(instr_busy);
    end
    chk(n, 5);
  endtask

  task automatic end_of_test;
    $display("checks=%0d errors=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // hang guard
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    end_of_test();
  end

  initial
  begin
    {rst_b, fetch_step, fetch_len, irq_take, irq_src, instr_start, instr_cycles, acc} = '0;
    req = '0;
    ctl = '0;
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 chk({stack_pointer, bank_sel, data_pointer}, {8'h07, 2'h0, 16'h0000});
    chk(fetch_addr, 13'h0000);
    t_banks();
    t_high();
    t_bits();
    t_stack();
    t_index();
    t_pc();
    t_reset();
    t_instr();
    end_of_test();
  end
endmodule
